// ### hw/phy_ctl_pkg.sv
package phy_ctl_pkg;
  // clock and software reset timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SRST_TIME_NS  = 80;
  localparam int SRST_CYC      = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // byte addresses of the register words
  localparam logic [3:0] ADDR_CTL  = 4'h0;
  localparam logic [3:0] ADDR_AUX  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_ADV  = 4'hc;

  // control and aux word bit positions
  localparam int CTL_SRST    = 15;
  localparam int CTL_SPD_LSB = 13;
  localparam int CTL_AN_EN   = 12;
  localparam int CTL_PD      = 11;
  localparam int CTL_AN_RST  = 9;
  localparam int CTL_DUP     = 8;
  localparam int CTL_SPD_MSB = 6;
  localparam int AUX_PD      = 2;

  // reset values
  localparam logic [1:0] RST_SPD    = 2'h2;
  localparam logic       RST_AN_EN  = 1'h1;
  localparam logic       RST_DUP    = 1'h1;
  localparam logic       RST_PD     = 1'h0;
  localparam logic       RST_AUX_PD = 1'h0;
  localparam logic [5:0] RST_ADV    = 6'h3f;

  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10,
    SPD_RSVD = 2'b11
  } spd_e;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_BUSY = 1'b1
  } seq_e;

  // byte-lane merge of a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction
endpackage

// ### hw/srst_if.sv
`timescale 1ns/1ps
interface srst_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport seq  (input start, output busy, output done);
endinterface

// ### hw/srst_seq.sv
`timescale 1ns/1ps
module srst_seq #(
  parameter int CYC = phy_ctl_pkg::SRST_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  srst_if.seq       sq
);
  import phy_ctl_pkg::*;

  localparam int SEQ_MAX = CYC + 1;

  typedef struct packed {
    seq_e        st;
    logic [15:0] cnt;
    logic        done;
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      SEQ_IDLE: begin
        if (sq.start) begin
          s_nxt.st  = SEQ_BUSY;
          s_nxt.cnt = 16'(CYC - 1);
        end
      end
      SEQ_BUSY: begin
        if (sq.start) begin
          s_nxt.cnt = 16'(CYC - 1);
        end else if (s_r.cnt == 16'h0000) begin
          s_nxt.st   = SEQ_IDLE;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end
      end
      default: s_nxt.st = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: SEQ_IDLE, cnt: 16'h0000, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sq.busy = (s_r.st == SEQ_BUSY);
  assign sq.done = s_r.done;

  srst_ends_a: assert property (@(posedge clk) disable iff (rst)
    sq.start |=> sq.busy ##[0:SEQ_MAX] sq.done)
    else $error("software reset did not complete in time");
  srst_clr_a: assert property (@(posedge clk) disable iff (rst)
    sq.done |-> !sq.busy)
    else $error("reset still busy when done");
endmodule

// ### hw/phy_copper_ctl.sv
`timescale 1ns/1ps
// Contract
// - speed bits 6,13: 10=1000, 01=100, 00=10
// - speed, duplex, autoneg writes wait for apply
// - forced gigabit still negotiates, advertising duplex bit
// - forced gigabit ignores 10/100 and gigabit advertisement
// - autoneg enable resets to one
// - power down leaves only when both bits zero
// - leaving power down resets and restarts autoneg
// - restart bit self-clears, reads zero
// - autoneg restarts after hardware or software reset
// - isolate and collision test read zero
// - duplex resets to one, full duplex
// - bit 15 resets state machines, self-clears
module phy_copper_ctl #(
  parameter int SRST_CYC = phy_ctl_pkg::SRST_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output phy_ctl_pkg::spd_e      speed_sel,
  output logic                   full_duplex,
  output logic                   an_active,
  output logic      [5:0]        adv_out,
  output logic                   an_restart,
  output logic                   phy_sreset,
  output logic                   powered_down
);
  import phy_ctl_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  spd;
    logic        an_en;
    logic        pd;
    logic        dup;
    logic        aux_pd;
    logic [5:0]  adv;
    logic [1:0]  spd_e;
    logic        an_en_e;
    logic        dup_e;
    logic        pd_q;
    logic        boot;
    logic        an_rst;
    logic        an_act;
    logic [5:0]  adv_o;
  } ctl_s;

  ctl_s s_r;
  ctl_s s_nxt;

  srst_if sq ();

  srst_seq #(
    .CYC (SRST_CYC)
  ) u_seq (
    .clk (clk),
    .rst (rst),
    .sq  (sq.seq)
  );

  logic        req;
  logic        wr_go;
  logic        wr_ctl;
  logic        an_wr;
  logic        pd_now;
  logic        pd_exit;
  logic        apply;
  logic        forced;
  logic [15:0] ctl_rd;
  logic [15:0] ctl_w;
  logic [15:0] aux_rd;
  logic [15:0] stat_rd;
  logic [15:0] adv_rd;
  logic [15:0] aux_w;
  logic [15:0] adv_w;

  always_comb begin
    // shadow view; restart and no-effect bits read zero, bit 15 reads the reset busy flag
    ctl_rd = 16'h0000;
    ctl_rd[CTL_SRST]    = sq.busy;
    ctl_rd[CTL_SPD_LSB] = s_r.spd[0];
    ctl_rd[CTL_AN_EN]   = s_r.an_en;
    ctl_rd[CTL_PD]      = s_r.pd;
    ctl_rd[CTL_DUP]     = s_r.dup;
    ctl_rd[CTL_SPD_MSB] = s_r.spd[1];
    aux_rd = 16'h0000;
    aux_rd[AUX_PD] = s_r.aux_pd;
    stat_rd = {s_r.spd_e, s_r.dup_e, s_r.an_en_e, pd_now, sq.busy, s_r.an_act,
               3'h0, s_r.adv_o};
    adv_rd = {10'h000, s_r.adv};
  end

  always_comb begin
    s_nxt   = s_r;
    req     = avs_read | avs_write;
    wr_go   = avs_write & s_r.ack;
    wr_ctl  = wr_go && (avs_address == ADDR_CTL);
    ctl_w   = merge16(ctl_rd, avs_writedata[15:0], avs_byteenable[1:0]);
    aux_w   = merge16(aux_rd, avs_writedata[15:0], avs_byteenable[1:0]);
    adv_w   = merge16(adv_rd, avs_writedata[15:0], avs_byteenable[1:0]);
    an_wr   = wr_ctl & avs_byteenable[1] & avs_writedata[CTL_AN_RST];
    pd_now  = s_r.pd | s_r.aux_pd;
    pd_exit = s_r.pd_q & ~pd_now;
    forced  = !s_r.an_en_e && (s_r.spd_e == SPD_1000);

    // one wait state: read data captured while waitrequest is high
    if (req && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      if (avs_address == ADDR_CTL) begin
        s_nxt.rdata = {16'h0000, ctl_rd};
      end else if (avs_address == ADDR_AUX) begin
        s_nxt.rdata = {16'h0000, aux_rd};
      end else if (avs_address == ADDR_STAT) begin
        s_nxt.rdata = {16'h0000, stat_rd};
      end else if (avs_address == ADDR_ADV) begin
        s_nxt.rdata = {16'h0000, adv_rd};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end else begin
      s_nxt.ack = 1'b0;
    end

    // speed, duplex and autoneg writes land in the shadow; power-down and advertisement writes act directly
    if (wr_ctl) begin
      s_nxt.spd   = {ctl_w[CTL_SPD_MSB], ctl_w[CTL_SPD_LSB]};
      s_nxt.an_en = ctl_w[CTL_AN_EN];
      s_nxt.pd    = ctl_w[CTL_PD];
      s_nxt.dup   = ctl_w[CTL_DUP];
    end else if (wr_go && (avs_address == ADDR_AUX)) begin
      s_nxt.aux_pd = aux_w[AUX_PD];
    end else if (wr_go && (avs_address == ADDR_ADV)) begin
      s_nxt.adv = adv_w[5:0];
    end

    // software reset: bit 15 write or power-down exit
    sq.start = (wr_ctl & avs_byteenable[1] & avs_writedata[CTL_SRST]) | pd_exit;
    apply    = sq.start | an_wr;
    if (apply) begin
      s_nxt.spd_e   = s_nxt.spd;
      s_nxt.an_en_e = s_nxt.an_en;
      s_nxt.dup_e   = s_nxt.dup;
    end

    s_nxt.pd_q   = pd_now;
    s_nxt.boot   = 1'b0;
    s_nxt.an_rst = s_r.boot | sq.done | an_wr | pd_exit;

    // forced gigabit still negotiates with a single advertisement
    s_nxt.an_act = s_r.an_en_e | forced;
    if (forced) begin
      s_nxt.adv_o = {s_r.dup_e, ~s_r.dup_e, 4'h0};
    end else begin
      s_nxt.adv_o = s_r.adv;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{ack: 1'b0, rdata: 32'h0000_0000,
               spd: RST_SPD, an_en: RST_AN_EN, pd: RST_PD, dup: RST_DUP,
               aux_pd: RST_AUX_PD, adv: RST_ADV,
               spd_e: RST_SPD, an_en_e: RST_AN_EN, dup_e: RST_DUP,
               pd_q: 1'b0, boot: 1'b1, an_rst: 1'b0, an_act: 1'b1,
               adv_o: RST_ADV};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_waitrequest = req & ~s_r.ack;
  assign avs_readdata    = s_r.rdata;
  assign speed_sel       = spd_e'(s_r.spd_e);
  assign full_duplex     = s_r.dup_e;
  assign an_active       = s_r.an_act;
  assign adv_out         = s_r.adv_o;
  assign an_restart      = s_r.an_rst;
  assign phy_sreset      = sq.busy;
  assign powered_down    = pd_now;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wait_bound_a: assert property (
    avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  speed_code_a: assert property (
    wr_ctl && apply |=> speed_sel[1] == $past(ctl_w[CTL_SPD_MSB])
      && speed_sel[0] == $past(ctl_w[CTL_SPD_LSB]))
    else $error("speed select decode mismatch");
  defer_hold_a: assert property (
    !apply |=> $stable(speed_sel) && $stable(full_duplex))
    else $error("applied mode changed without apply event");
  defer_take_a: assert property (
    wr_ctl && apply |=> s_r.dup_e == $past(ctl_w[CTL_DUP]))
    else $error("applied duplex not taken from shadow");
  forced_gig_a: assert property (
    forced |=> an_active && adv_out[5] == $past(s_r.dup_e) && adv_out[4] == !$past(s_r.dup_e))
    else $error("forced gigabit advertisement wrong");
  adv_ignore_a: assert property (
    forced |=> adv_out[3:0] == 4'h0)
    else $error("10/100 advertisement not ignored");
  boot_vals_a: assert property (
    s_r.boot |-> s_r.an_en && s_r.an_en_e && s_r.dup && s_r.dup_e)
    else $error("autoneg or duplex reset value wrong");
  pd_both_a: assert property (
    powered_down |-> s_r.pd || s_r.aux_pd)
    else $error("power down without a bit set");
  pd_exit_a: assert property (
    $fell(powered_down) |=> phy_sreset ##0 an_restart)
    else $error("power-down exit did not reset and restart");
  restart_sc_a: assert property (
    an_wr |=> an_restart ##1 (!an_restart || $past(sq.done)))
    else $error("restart write not a single pulse");
  boot_restart_a: assert property (
    s_r.boot |=> an_restart)
    else $error("no restart after hardware reset");
  srst_restart_a: assert property (
    sq.done |=> an_restart)
    else $error("no restart after software reset");
  ro_zero_a: assert property (
    s_r.ack && avs_read && avs_address == ADDR_CTL |-> avs_readdata[10:9] == 2'b00
      && avs_readdata[7] == 1'b0 && avs_readdata[5:0] == 6'h00)
    else $error("read-only control bits not zero");
  srst_bit_a: assert property (
    s_r.ack && avs_read && avs_address == ADDR_CTL
      |-> avs_readdata[CTL_SRST] == $past(phy_sreset))
    else $error("reset bit not shown while busy");
endmodule

// ### verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output logic      [3:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end

  // one access, held until waitrequest is seen low
  task automatic access(input logic [3:0] a, input logic wr, input logic [15:0] d,
                        input logic [1:0] be, output logic [15:0] q);
    @(posedge clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= {16'h0, d};
    byteenable <= {2'b00, be};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read       <= 1'b0;
    write      <= 1'b0;
    address    <= ~a;
    writedata  <= ~writedata;
  endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import phy_ctl_pkg::*;
  localparam int SRST_TB = 3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic read, write, waitrequest;
  spd_e speed_sel;
  logic full_duplex, an_active, an_restart, phy_sreset, powered_down;
  logic [5:0] adv_out;
  int failures = 0;
  int checks = 0;
  int restarts = 0;
  int cyc = 0;
  int n;

  always #5 clk = ~clk;

  host_model host_u (.clk(clk), .readdata(readdata), .waitrequest(waitrequest),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable));

  phy_copper_ctl #(.SRST_CYC(SRST_TB)) dut_u (.clk(clk), .rst(rst),
    .avs_address(address), .avs_read(read), .avs_write(write),
    .avs_writedata(writedata), .avs_byteenable(byteenable),
    .avs_readdata(readdata), .avs_waitrequest(waitrequest),
    .speed_sel(speed_sel), .full_duplex(full_duplex), .an_active(an_active),
    .adv_out(adv_out), .an_restart(an_restart), .phy_sreset(phy_sreset),
    .powered_down(powered_down));

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (an_restart === 1'b1) restarts <= restarts + 1;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    host_u.access(a, 1'b1, d, 2'b11, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] q;
    host_u.access(a, 1'b0, 16'h0, 2'b11, q);
    chk(q, e, "read data");
  endtask

  task automatic outs(input logic [15:0] e);
    chk(16'({speed_sel, full_duplex, an_active, powered_down}), e, "applied state");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(16'(restarts), 16'h1, "hw reset restart");
    rd(ADDR_CTL, 16'h1140);
    outs(16'h0016);
    rd(4'h2, 16'h0000);
    wr(ADDR_CTL, 16'h24bf);
    rd(ADDR_CTL, 16'h2000);
    outs(16'h0016);
    wr(ADDR_CTL, 16'h2200);
    repeat (2) @(posedge clk);
    outs(16'h0008);
    chk(16'(restarts), 16'h2, "restart pulse");
    rd(ADDR_CTL, 16'h2000);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_ADV, 16'h000f);
      wr(ADDR_CTL, i ? 16'h0340 : 16'h0240);
      repeat (2) @(posedge clk);
      chk(16'({speed_sel, an_active, adv_out}), 16'({SPD_1000, 1'b1,
          i ? 6'h20 : 6'h10}), "forced gigabit");
    end
    wr(ADDR_CTL, 16'h8000);
    n = 0;
    repeat (SRST_TB + 4) begin
      #1;
      if (phy_sreset === 1'b1) n++;
      @(posedge clk);
    end
    chk(16'(n), 16'(SRST_TB), "sreset length");
    outs(16'h0000);
    chk(16'(restarts), 16'h5, "sreset restart");
    rd(ADDR_CTL, 16'h0000);
    wr(ADDR_AUX, 16'h0004);
    wr(ADDR_CTL, 16'h0800);
    wr(ADDR_CTL, 16'h2100);
    repeat (2) @(posedge clk);
    outs(16'h0001);
    wr(ADDR_AUX, 16'h0000);
    repeat (SRST_TB + 6) @(posedge clk);
    outs(16'h000c);
    chk(16'(restarts), 16'h7, "power up restarts");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    outs(16'h0016);
    chk(16'(restarts), 16'h8, "second hw restart");
    rd(ADDR_STAT, 16'hb23f);
    complete_run();
  end
endmodule
